// ===== shared/madc_pkg.sv
// Operation
// - Hold position detection state while hold bit set and startup uses it.
// - Hold speed detection state while hold bit set and detection enabled.
// - Inner loop disable stops both loops; forced fields drive d/q commands.
// - Forced d field: up to 500 is value/500, from 524 up is (value-1024)/500.
// - Forced q field decodes alike; 501 to 523 are invalid.
// - Writing one to measurement command starts parameter measurement.
// - Back-EMF measure enable includes back-EMF constant measurement.
// - Mechanical measure enable includes mechanical parameter measurement.
// - Writing one to measured-to-shadow copies results into shadow config.
// - Current gain readback is read-only, integral high, proportional low.
// - Speed gain readback is read-only, integral high, proportional low.
// - Variable at 12-bit monitor address is scaled onto monitor output.
// - Scaling codes 1..15 give n/8; code 0 treats variable as enum <= 31.
// - With scaling zero, variable is multiplied by 2 to the multiplier.
// - Polarity zero gives bipolar output around mid-scale; one unipolar.
// - EEPROM access allowed only when user key equals stored lock key.
// - Store bit copies shadow to EEPROM; load bit copies EEPROM to shadow.
// - Fault clear and retry count clear pulse once and are write-only.
// - Host tickles watchdog bit each period; device returns it to zero.
package madc_pkg;
	localparam logic [11:0] OFS_DEVICE_COMMAND = 12'h0EA;
	localparam logic [11:0] OFS_STARTUP_OVERRIDE = 12'h0EC;
	localparam logic [11:0] OFS_LOOP_OVERRIDE = 12'h0EE;
	localparam logic [11:0] OFS_CURRENT_GAIN = 12'h0F0;
	localparam logic [11:0] OFS_SPEED_GAIN = 12'h0F2;
	localparam logic [11:0] OFS_MONITOR_CFG = 12'h0F4;
	localparam logic [11:0] OFS_NVM_KEY = 12'h0F6;

	localparam int CMD_STORE_BIT = 31;
	localparam int CMD_LOAD_BIT = 30;
	localparam int CMD_FAULT_CLEAR_BIT = 29;
	localparam int CMD_RETRY_CLEAR_BIT = 28;
	localparam int CMD_KEY_LSB = 20;
	localparam int CMD_TICKLE_BIT = 10;
	localparam logic [7:0] WRITE_ACCESS_KEY = 8'hA5;

	localparam int SO_HOLD_IPD_BIT = 12;
	localparam int SO_HOLD_ISD_BIT = 11;

	localparam int LO_INNER_DIS_BIT = 26;
	localparam int LO_VD_LSB = 16;
	localparam int LO_VQ_LSB = 6;
	localparam int LO_MEAS_CMD_BIT = 5;
	localparam int LO_KE_BIT = 2;
	localparam int LO_MECH_BIT = 1;
	localparam int LO_SHADOW_BIT = 0;

	localparam int GAIN_HI_LSB = 16;

	localparam int MON_MULT_LSB = 17;
	localparam int MON_SCALE_LSB = 13;
	localparam int MON_POL_BIT = 12;

	localparam logic [9:0] FORCE_POS_MAX = 10'h1F4;
	localparam logic [9:0] FORCE_NEG_MIN = 10'h20C;
	localparam logic [10:0] FORCE_WRAP = 11'h400;
	localparam logic [15:0] ENUM_MAX = 16'h001F;
	localparam logic [11:0] DAC_MID = 12'h800;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} madc_req_s;

	typedef struct packed {
		logic [9:0] integral;
		logic [9:0] proportional;
	} madc_gain_s;

	typedef struct packed {
		logic [3:0] mult;
		logic [3:0] scale;
		logic unipolar;
		logic [11:0] addr;
	} madc_mon_s;
endpackage

// ===== core/madc_monitor.sv
`timescale 1ns/1ps
// Scales the fetched algorithm variable into a 12-bit monitor DAC code.
module madc_monitor (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire madc_pkg::madc_mon_s cfg_in,
	input wire logic signed [15:0] var_data_in,
	output logic [11:0] dac_code_out
);
	wire logic signed [20:0] gain_prod;
	wire logic signed [20:0] scaled;
	wire logic [15:0] enum_val;
	wire logic [31:0] enum_shift;
	wire logic signed [20:0] active;
	wire logic signed [20:0] bip_sum;
	wire logic [11:0] code_d;

	assign gain_prod = var_data_in * $signed({1'b0, cfg_in.scale});
	assign scaled = gain_prod >>> 3;
	// Enumerations are clamped to their maximum before the power-of-two gain.
	assign enum_val = (var_data_in < 0) ? 16'h0000 :
		((var_data_in > $signed(madc_pkg::ENUM_MAX)) ?
		madc_pkg::ENUM_MAX : var_data_in);
	assign enum_shift = {16'h0000, enum_val} << cfg_in.mult;
	assign active = (cfg_in.scale == 4'h0) ?
		$signed({1'b0, enum_shift[19:0]}) : scaled;
	assign bip_sum = (active >>> 5) + $signed({9'h000, madc_pkg::DAC_MID});
	// Unipolar clips negatives to zero; bipolar centres on mid-scale.
	assign code_d = cfg_in.unipolar ?
		((active < 0) ? 12'h000 :
		((active > 21'sh000FFF) ? 12'hFFF : active[11:0])) :
		((bip_sum < 0) ? 12'h000 :
		((bip_sum > 21'sh000FFF) ? 12'hFFF : bip_sum[11:0]));

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dac_code_out <= 12'h000;
		end else begin
			dac_code_out <= code_d;
		end
	end
endmodule

// ===== core/madc_regs.sv
`timescale 1ns/1ps
// Debug and control register bank of the motor control engine.
module madc_regs (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire madc_pkg::madc_req_s req_in,
	output logic [31:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic startup_is_ipd_in,
	input wire logic speed_detect_enable_in,
	input wire madc_pkg::madc_gain_s inner_gain_in,
	input wire madc_pkg::madc_gain_s outer_gain_in,
	input wire logic signed [15:0] monitor_var_data_in,
	input wire logic [14:0] nvm_lock_key_in,
	output logic hold_position_detect_out,
	output logic hold_speed_detect_out,
	output logic inner_loop_disable_out,
	output logic outer_loop_disable_out,
	output logic signed [10:0] d_modulation_reference_out,
	output logic signed [10:0] q_modulation_reference_out,
	output logic d_reference_valid_out,
	output logic q_reference_valid_out,
	output logic measurement_start_out,
	output logic backemf_measure_enable_out,
	output logic mechanical_measure_enable_out,
	output logic measured_to_shadow_out,
	output logic [11:0] monitor_address_out,
	output logic [11:0] monitor_output_out,
	output logic nvm_access_allowed_out,
	output logic store_config_out,
	output logic load_config_out,
	output logic fault_clear_out,
	output logic retry_count_clear_out,
	output logic watchdog_tickle_out
);
	logic [7:0] access_key_q;
	logic [7:0] access_key_d;
	logic [1:0] startup_q;
	logic [1:0] startup_d;
	logic [24:0] loop_q;
	logic [24:0] loop_d;
	madc_pkg::madc_mon_s mon_q;
	madc_pkg::madc_mon_s mon_d;
	logic [14:0] user_key_q;
	logic [14:0] user_key_d;
	logic [31:0] rdata_d;

	wire logic hit_cmd;
	wire logic hit_so;
	wire logic hit_lo;
	wire logic hit_cg;
	wire logic hit_sg;
	wire logic hit_mon;
	wire logic hit_key;
	wire logic wr_cmd;
	wire logic wr_lo;
	wire logic [31:0] wd;
	wire logic [9:0] vd_field;
	wire logic [9:0] vq_field;
	wire logic inner_dis;
	wire logic key_match;
	wire logic store_ok;
	wire logic [31:0] rd_cmd;
	wire logic [31:0] rd_so;
	wire logic [31:0] rd_lo;
	wire logic [31:0] rd_cg;
	wire logic [31:0] rd_sg;
	wire logic [31:0] rd_mon;
	wire logic [31:0] rd_key;
	wire logic signed [10:0] vd_ref;
	wire logic signed [10:0] vq_ref;
	wire logic vd_ok;
	wire logic vq_ok;

	assign wd = req_in.wdata;
	assign hit_cmd = (req_in.addr == madc_pkg::OFS_DEVICE_COMMAND);
	assign hit_so = (req_in.addr == madc_pkg::OFS_STARTUP_OVERRIDE);
	assign hit_lo = (req_in.addr == madc_pkg::OFS_LOOP_OVERRIDE);
	assign hit_cg = (req_in.addr == madc_pkg::OFS_CURRENT_GAIN);
	assign hit_sg = (req_in.addr == madc_pkg::OFS_SPEED_GAIN);
	assign hit_mon = (req_in.addr == madc_pkg::OFS_MONITOR_CFG);
	assign hit_key = (req_in.addr == madc_pkg::OFS_NVM_KEY);
	assign wr_cmd = req_in.wr & hit_cmd;
	assign wr_lo = req_in.wr & hit_lo;

	// Next values of the stored fields; readback-only registers take no write.
	assign access_key_d = wr_cmd ? wd[madc_pkg::CMD_KEY_LSB +: 8] :
		access_key_q;
	assign startup_d = (req_in.wr & hit_so) ?
		{wd[madc_pkg::SO_HOLD_IPD_BIT], wd[madc_pkg::SO_HOLD_ISD_BIT]} :
		startup_q;
	assign loop_d = wr_lo ? {wd[madc_pkg::LO_INNER_DIS_BIT],
		wd[madc_pkg::LO_VD_LSB +: 10], wd[madc_pkg::LO_VQ_LSB +: 10],
		wd[madc_pkg::LO_MEAS_CMD_BIT], wd[madc_pkg::LO_KE_BIT],
		wd[madc_pkg::LO_MECH_BIT], wd[madc_pkg::LO_SHADOW_BIT]} :
		loop_q;
	assign mon_d = (req_in.wr & hit_mon) ? madc_pkg::madc_mon_s'(
		{wd[madc_pkg::MON_MULT_LSB +: 4], wd[madc_pkg::MON_SCALE_LSB +: 4],
		wd[madc_pkg::MON_POL_BIT], wd[11:0]}) : mon_q;
	assign user_key_d = (req_in.wr & hit_key) ? wd[14:0] : user_key_q;

	assign inner_dis = loop_q[24];
	assign vd_field = loop_q[23:14];
	assign vq_field = loop_q[13:4];

	// Forced voltage codes in 1/500 steps; the dead band 501..523 is invalid.
	assign vd_ok = (vd_field <= madc_pkg::FORCE_POS_MAX) |
		(vd_field >= madc_pkg::FORCE_NEG_MIN);
	assign vd_ref = !vd_ok ? 11'sh000 :
		((vd_field <= madc_pkg::FORCE_POS_MAX) ? $signed({1'b0, vd_field}) :
		$signed({1'b0, vd_field} - madc_pkg::FORCE_WRAP));
	assign vq_ok = (vq_field <= madc_pkg::FORCE_POS_MAX) |
		(vq_field >= madc_pkg::FORCE_NEG_MIN);
	assign vq_ref = !vq_ok ? 11'sh000 :
		((vq_field <= madc_pkg::FORCE_POS_MAX) ? $signed({1'b0, vq_field}) :
		$signed({1'b0, vq_field} - madc_pkg::FORCE_WRAP));

	assign key_match = (user_key_q == nvm_lock_key_in);
	// A store needs both the matching user key and the write access key.
	assign store_ok = key_match &
		(wd[madc_pkg::CMD_KEY_LSB +: 8] == madc_pkg::WRITE_ACCESS_KEY);

	// Command, tickle and clear bits are acted on at once and read as zero.
	assign rd_cmd = {4'h0, access_key_q, 20'h00000};
	assign rd_so = {19'h00000, startup_q[1], startup_q[0], 11'h000};
	assign rd_lo = {5'h00, loop_q[24:4], loop_q[3], 2'h0,
		loop_q[2], loop_q[1], loop_q[0]};
	assign rd_cg = {6'h00, inner_gain_in.integral,
		6'h00, inner_gain_in.proportional};
	assign rd_sg = {6'h00, outer_gain_in.integral,
		6'h00, outer_gain_in.proportional};
	assign rd_mon = {11'h000, mon_q.mult, mon_q.scale,
		mon_q.unipolar, mon_q.addr};
	assign rd_key = {17'h00000, user_key_q};

	always_comb begin
		if (hit_cmd) begin
			rdata_d = rd_cmd;
		end else if (hit_so) begin
			rdata_d = rd_so;
		end else if (hit_lo) begin
			rdata_d = rd_lo;
		end else if (hit_cg) begin
			rdata_d = rd_cg;
		end else if (hit_sg) begin
			rdata_d = rd_sg;
		end else if (hit_mon) begin
			rdata_d = rd_mon;
		end else if (hit_key) begin
			rdata_d = rd_key;
		end else begin
			rdata_d = madc_pkg::RESET_WORD;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			access_key_q <= 8'h00;
			startup_q <= 2'h0;
			loop_q <= 25'h0000000;
			mon_q <= '0;
			user_key_q <= 15'h0000;
		end else begin
			access_key_q <= access_key_d;
			startup_q <= startup_d;
			loop_q <= loop_d;
			mon_q <= mon_d;
			user_key_q <= user_key_d;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 32'h0000_0000;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rdata_out <= req_in.rd ? rdata_d : 32'h0000_0000;
			reg_rvalid_out <= req_in.rd;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hold_position_detect_out <= 1'b0;
			hold_speed_detect_out <= 1'b0;
			inner_loop_disable_out <= 1'b0;
			outer_loop_disable_out <= 1'b0;
			d_modulation_reference_out <= 11'sh000;
			q_modulation_reference_out <= 11'sh000;
			d_reference_valid_out <= 1'b0;
			q_reference_valid_out <= 1'b0;
			backemf_measure_enable_out <= 1'b0;
			mechanical_measure_enable_out <= 1'b0;
			monitor_address_out <= 12'h000;
			nvm_access_allowed_out <= 1'b0;
		end else begin
			hold_position_detect_out <= startup_q[1] & startup_is_ipd_in;
			hold_speed_detect_out <= startup_q[0] & speed_detect_enable_in;
			inner_loop_disable_out <= inner_dis;
			outer_loop_disable_out <= inner_dis;
			d_modulation_reference_out <= inner_dis ? vd_ref : 11'sh000;
			q_modulation_reference_out <= inner_dis ? vq_ref : 11'sh000;
			d_reference_valid_out <= inner_dis & vd_ok;
			q_reference_valid_out <= inner_dis & vq_ok;
			backemf_measure_enable_out <= loop_q[2];
			mechanical_measure_enable_out <= loop_q[1];
			monitor_address_out <= mon_q.addr;
			nvm_access_allowed_out <= key_match;
		end
	end

	// One-cycle command pulses taken straight from the accepted write.
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			measurement_start_out <= 1'b0;
			measured_to_shadow_out <= 1'b0;
			store_config_out <= 1'b0;
			load_config_out <= 1'b0;
			fault_clear_out <= 1'b0;
			retry_count_clear_out <= 1'b0;
			watchdog_tickle_out <= 1'b0;
		end else begin
			measurement_start_out <= wr_lo &
				wd[madc_pkg::LO_MEAS_CMD_BIT];
			measured_to_shadow_out <= wr_lo &
				wd[madc_pkg::LO_SHADOW_BIT];
			store_config_out <= wr_cmd & store_ok &
				wd[madc_pkg::CMD_STORE_BIT];
			load_config_out <= wr_cmd & key_match &
				wd[madc_pkg::CMD_LOAD_BIT];
			fault_clear_out <= wr_cmd &
				wd[madc_pkg::CMD_FAULT_CLEAR_BIT];
			retry_count_clear_out <= wr_cmd &
				wd[madc_pkg::CMD_RETRY_CLEAR_BIT];
			watchdog_tickle_out <= wr_cmd &
				wd[madc_pkg::CMD_TICKLE_BIT];
		end
	end

	madc_monitor u_monitor (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.cfg_in(mon_q),
		.var_data_in(monitor_var_data_in),
		.dac_code_out(monitor_output_out)
	);
endmodule

// ===== test/madc_regs_sva.sv
`timescale 1ns/1ps
module madc_regs_sva (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire madc_pkg::madc_req_s req_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire madc_pkg::madc_gain_s inner_gain_in,
	input wire logic startup_is_ipd_in,
	input wire logic nvm_access_allowed_out,
	input wire logic hold_position_detect_out,
	input wire logic inner_loop_disable_out,
	input wire logic outer_loop_disable_out,
	input wire logic signed [10:0] d_modulation_reference_out,
	input wire logic d_reference_valid_out,
	input wire logic measurement_start_out,
	input wire logic measured_to_shadow_out,
	input wire logic store_config_out,
	input wire logic fault_clear_out,
	input wire logic watchdog_tickle_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);
	wire [11:0] ad = req_in.addr;
	wire [31:0] wd = req_in.wdata;
	wire cmd_wr = req_in.wr && ad == madc_pkg::OFS_DEVICE_COMMAND;
	wire so_wr = req_in.wr && ad == madc_pkg::OFS_STARTUP_OVERRIDE;
	wire lo_wr = req_in.wr && ad == madc_pkg::OFS_LOOP_OVERRIDE;
	wire shadow_wr = lo_wr && wd[0];
	wire tickle_wr = cmd_wr && wd[10];
	wire store_ok = cmd_wr && wd[31] && wd[27:20] == 8'hA5 &&
		nvm_access_allowed_out;

	AST_UNMAPPED_READ: assert property (
		req_in.rd && ad == 12'h0F8 |=> reg_rvalid_out && reg_rdata_out == 32'h0)
		else $error("unmapped read not zero");
	AST_CUR_GAIN: assert property (
		req_in.rd && ad == madc_pkg::OFS_CURRENT_GAIN |=>
		reg_rdata_out == {6'h00, $past(inner_gain_in.integral), 6'h00,
		$past(inner_gain_in.proportional)})
		else $error("current gain readback wrong");
	AST_LOOP_PAIR: assert property (
		inner_loop_disable_out == outer_loop_disable_out)
		else $error("loop disables differ");
	AST_REF_OFF: assert property (
		!inner_loop_disable_out |->
		d_modulation_reference_out == 11'h000 && !d_reference_valid_out)
		else $error("forced reference while loops enabled");
	AST_HOLD_POS: assert property (
		(so_wr && wd[12] && startup_is_ipd_in) ##1
		(!so_wr && startup_is_ipd_in)[*2] |-> hold_position_detect_out)
		else $error("position detect not held");
	AST_MEAS_START: assert property (
		lo_wr && wd[5] |=> measurement_start_out)
		else $error("measurement start missing");
	AST_SHADOW: assert property (
		measured_to_shadow_out |-> $past(shadow_wr))
		else $error("shadow copy without write");
	AST_FAULT_CLEAR: assert property (
		cmd_wr && wd[29] |=> fault_clear_out)
		else $error("fault clear missing");
	AST_TICKLE: assert property (
		tickle_wr ##1 !tickle_wr |-> watchdog_tickle_out ##1 !watchdog_tickle_out)
		else $error("tickle not a single pulse");
	AST_STORE: assert property (
		store_config_out |-> $past(store_ok))
		else $error("store without key");

	COV_FORCED: cover property (inner_loop_disable_out && d_reference_valid_out);
	COV_STORE: cover property (store_config_out);
	COV_HOLD: cover property (hold_position_detect_out);
endmodule

bind madc_regs madc_regs_sva u_sva (.sys_clk_in, .resetn_in, .req_in,
	.reg_rdata_out, .reg_rvalid_out, .inner_gain_in, .startup_is_ipd_in,
	.nvm_access_allowed_out, .hold_position_detect_out,
	.inner_loop_disable_out, .outer_loop_disable_out,
	.d_modulation_reference_out, .d_reference_valid_out,
	.measurement_start_out, .measured_to_shadow_out, .store_config_out,
	.fault_clear_out, .watchdog_tickle_out);

// ===== test/madc_regs_tb_top.sv
`timescale 1ns/1ps
module madc_regs_tb_top;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	madc_pkg::madc_req_s req = '0;
	madc_pkg::madc_gain_s ig = '0;
	madc_pkg::madc_gain_s og = '0;
	logic initial_position_detection = 1'b0;
	logic sde = 1'b0;
	logic signed [15:0] mvar = 16'h0000;
	logic [14:0] lock = 15'h0000;
	logic [31:0] rdata;
	logic signed [10:0] dref, qref;
	logic [11:0] maddr, mout;
	logic rv, hp, hs, il, ol, dv, qv, ms, bk, mc, sh, na, st, ld, fc, rc, wt;
	int fails = 0;
	int checked = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	madc_regs dut (.sys_clk_in, .resetn_in, .req_in(req),
		.reg_rdata_out(rdata), .reg_rvalid_out(rv),
		.startup_is_ipd_in(initial_position_detection), .speed_detect_enable_in(sde),
		.inner_gain_in(ig), .outer_gain_in(og),
		.monitor_var_data_in(mvar), .nvm_lock_key_in(lock),
		.hold_position_detect_out(hp), .hold_speed_detect_out(hs),
		.inner_loop_disable_out(il), .outer_loop_disable_out(ol),
		.d_modulation_reference_out(dref),
		.q_modulation_reference_out(qref),
		.d_reference_valid_out(dv), .q_reference_valid_out(qv),
		.measurement_start_out(ms), .backemf_measure_enable_out(bk),
		.mechanical_measure_enable_out(mc), .measured_to_shadow_out(sh),
		.monitor_address_out(maddr), .monitor_output_out(mout),
		.nvm_access_allowed_out(na), .store_config_out(st),
		.load_config_out(ld), .fault_clear_out(fc),
		.retry_count_clear_out(rc), .watchdog_tickle_out(wt));

	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic nx(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge sys_clk_in);
		req = '{1'b1, 1'b0, a, d};
		@(negedge sys_clk_in);
		req = '0;
	endtask

	// A read that brings no valid strobe returns a marker that never matches.
	task automatic rchk(input string n, input logic [11:0] a,
		input logic [31:0] e);
		@(negedge sys_clk_in);
		req = '{1'b0, 1'b1, a, 32'h0};
		@(negedge sys_clk_in);
		req = '0;
		chk(n, rv === 1'b1 ? rdata : 32'hDEAD_BEEF, e);
	endtask

	task automatic t_reset;
		logic [11:0] ofs [7] = '{12'h0EA, 12'h0EC, 12'h0EE, 12'h0F0,
			12'h0F2, 12'h0F4, 12'h0F6};
		foreach (ofs[i]) rchk("reset", ofs[i], 32'h0);
		wr(12'h0F8, 32'hFFFF_FFFF);
		rchk("unmapped", 12'h0F8, 32'h0);
	endtask

	task automatic t_loop;
		logic [9:0] v [6] = '{10'h000, 10'h1F4, 10'h1F5, 10'h20B,
			10'h20C, 10'h3FF};
		int e;
		foreach (v[i]) begin
			wr(madc_pkg::OFS_LOOP_OVERRIDE, {5'h1F, 1'b1, v[i], v[i], 6'h18});
			nx(1);
			e = v[i] <= 500 ? v[i] : v[i] >= 524 ? v[i] - 1024 : 0;
			chk("loops", {30'h0, il, ol}, 32'h3);
			chk("dref", {21'h0, dref}, {21'h0, 11'(e)});
			chk("qref", {21'h0, qref}, {21'h0, 11'(e)});
			chk("valid", {30'h0, dv, qv}, {30'h0, {2{e != 0 || i == 0}}});
		end
		rchk("dbg2", madc_pkg::OFS_LOOP_OVERRIDE, 32'h07FF_FFC0);
		wr(madc_pkg::OFS_LOOP_OVERRIDE, 32'h03FF_FFC0);
		nx(1);
		chk("off", {29'h0, il, dv, qv}, 32'h0);
		chk("offref", {21'h0, dref}, 32'h0);
	endtask

	task automatic t_meas;
		wr(madc_pkg::OFS_LOOP_OVERRIDE, 32'h0000_0027);
		chk("pulses", {30'h0, ms, sh}, 32'h3);
		nx(1);
		chk("enables", {28'h0, bk, mc, ms, sh}, 32'hC);
		rchk("dbg2", madc_pkg::OFS_LOOP_OVERRIDE, 32'h0000_0027);
		wr(madc_pkg::OFS_LOOP_OVERRIDE, 32'h0000_0004);
		chk("nopulse", {30'h0, ms, sh}, 32'h0);
		nx(1);
		chk("enables", {30'h0, bk, mc}, 32'h2);
	endtask

	task automatic t_gain;
		ig = '{10'h2AB, 10'h155};
		og = '{10'h3C1, 10'h00F};
		rchk("cur", madc_pkg::OFS_CURRENT_GAIN, 32'h02AB_0155);
		wr(madc_pkg::OFS_CURRENT_GAIN, 32'hFFFF_FFFF);
		rchk("cur", madc_pkg::OFS_CURRENT_GAIN, 32'h02AB_0155);
		wr(madc_pkg::OFS_SPEED_GAIN, 32'hFFFF_FFFF);
		rchk("spd", madc_pkg::OFS_SPEED_GAIN, 32'h03C1_000F);
	endtask

	task automatic t_start;
		initial_position_detection = 1'b1;
		wr(madc_pkg::OFS_STARTUP_OVERRIDE, 32'h0000_3FFF);
		nx(1);
		chk("hold", {30'h0, hp, hs}, 32'h2);
		nx(1);
		initial_position_detection = 1'b0;
		sde = 1'b1;
		nx(2);
		chk("hold", {30'h0, hp, hs}, 32'h1);
		rchk("dbg1", madc_pkg::OFS_STARTUP_OVERRIDE, 32'h0000_1800);
		wr(madc_pkg::OFS_STARTUP_OVERRIDE, 32'h0);
		nx(1);
		chk("release", {30'h0, hp, hs}, 32'h0);
	endtask

	task automatic t_mon;
		logic [31:0] c [4] = '{32'h0000_5ABC, 32'h0000_FABC, 32'h0001_0ABC,
			32'h0004_1ABC};
		logic [15:0] x [4] = '{16'h0190, 16'h0040, 16'hFEC0, 16'h0028};
		logic [11:0] e [4] = '{12'h064, 12'h038, 12'h7F6, 12'h07C};
		foreach (c[i]) begin
			mvar = x[i];
			wr(madc_pkg::OFS_MONITOR_CFG, c[i] | 32'hFFE0_0000);
			nx(3);
			chk("addr", {20'h0, maddr}, 32'h0ABC);
			chk("dac", {20'h0, mout}, {20'h0, e[i]});
			rchk("mon", madc_pkg::OFS_MONITOR_CFG, c[i]);
		end
	endtask

	task automatic t_nvm;
		lock = 15'h1234;
		wr(madc_pkg::OFS_NVM_KEY, 32'hFFFF_9234);
		nx(1);
		chk("allow", {31'h0, na}, 32'h1);
		rchk("key", madc_pkg::OFS_NVM_KEY, 32'h0000_1234);
		wr(madc_pkg::OFS_DEVICE_COMMAND, 32'hFFFF_FFFF);
		chk("cmd", {27'h0, st, ld, fc, rc, wt}, 32'h0F);
		wr(madc_pkg::OFS_DEVICE_COMMAND, 32'hFA50_0400);
		chk("cmd", {27'h0, st, ld, fc, rc, wt}, 32'h1F);
		rchk("cmd", madc_pkg::OFS_DEVICE_COMMAND, 32'h0A50_0000);
		wr(madc_pkg::OFS_NVM_KEY, 32'h0000_0001);
		nx(1);
		chk("deny", {31'h0, na}, 32'h0);
		wr(madc_pkg::OFS_DEVICE_COMMAND, 32'hFA50_0000);
		chk("cmd", {27'h0, st, ld, fc, rc, wt}, 32'h06);
	endtask

	task automatic print_verdict;
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		nx(6);
		resetn_in = 1'b1;
		t_reset();
		t_loop();
		t_meas();
		t_gain();
		t_start();
		t_mon();
		t_nvm();
		print_verdict();
	end
endmodule
